// [include/card_flags_pkg.sv]
// constants and rule summary for the smart card status flag block
// Behaviour
// - card flag rules only while card mode selected
// - tx empty set when disabled or transferred
// - tx empty clears by read-one then write-zero
// - controller write to holding clears tx empty
// - rx full set on clean reception transfer
// - rx full clears by sequence or controller read
// - receive disable leaves rx full unchanged
// - overrun set on reception while full
// - error signal flag set on sampled low
// - parity error flag set on detected error
// - transmit end flag is read only
// - transmit end held while disabled, no error
// - transmit end set after mode-dependent delay
// - transmit end clears with tx empty clear
// - delays counted in half element time units
// - rx multiproc bit reads idle in card mode
package card_flags_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h1;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFF_IRQ_CLR = 4'h3;
  localparam logic [3:0] OFF_IRQ_EN = 4'h4;
  // status bit positions
  localparam int unsigned B_TXE = 7;
  localparam int unsigned B_RXF = 6;
  localparam int unsigned B_ORE = 5;
  localparam int unsigned B_ERS = 4;
  localparam int unsigned B_PER = 3;
  localparam int unsigned B_TRANSMIT_END = 2;
  localparam int unsigned B_MPB = 1;
  localparam int unsigned B_TX_MULTIPROC_BIT = 0;
  // control bit positions
  localparam int unsigned C_TE = 0;
  localparam int unsigned C_RE = 1;
  localparam int unsigned C_CARD = 2;
  localparam int unsigned C_GSM = 3;
  localparam int unsigned C_BLK = 4;
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // delay in half element time units
  localparam logic [3:0] HALF_ETU_2P5 = 4'h5;
  localparam logic [3:0] HALF_ETU_1P5 = 4'h3;
  localparam logic [3:0] HALF_ETU_1P0 = 4'h2;
  // interrupt event bits
  localparam int unsigned EV_W = 5;
  localparam int unsigned EV_TXE = 0;
  localparam int unsigned EV_RXF = 1;
  localparam int unsigned EV_ORE = 2;
  localparam int unsigned EV_ERS = 3;
  localparam int unsigned EV_TRANSMIT_END = 4;
  localparam logic [15:0] HALF_ETU_CYCLES_DEFAULT = 16'h0004;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_TIMING = 2'b01,
    TX_DONE = 2'b10
  } tx_state_e;
endpackage

// [hdl/half_etu_tick.sv]
// half element time unit enable pulse divider
`timescale 1ns/100ps
module half_etu_tick #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [CNT_W-1:0] period,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;
  initial begin
    if (CNT_W < 2) $error("half_etu_tick: CNT_W too small");
  end
  // restart aligns the grid to the byte start
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = '0;
    end else if (cnt_q + 1'b1 >= period) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick = tick_q;
endmodule

// [hdl/card_status_flags.sv]
// smart card status flags with register port and interrupt
`timescale 1ns/100ps
module card_status_flags #(
  parameter logic [15:0] HALF_ETU_CYCLES = card_flags_pkg::HALF_ETU_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [card_flags_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_load,
  input wire logic tx_byte_start,
  input wire logic rx_done,
  input wire logic rx_parity_bad,
  input wire logic rx_mpb,
  input wire logic err_sig_low,
  input wire logic ctl_tx_write,
  input wire logic ctl_rx_read,
  output logic transmit_enable,
  output logic receive_enable,
  output logic tx_holding_empty,
  output logic rx_holding_full,
  output logic irq
);
  import card_flags_pkg::*;

  initial begin
    if (HALF_ETU_CYCLES < 16'h0002) $error("card_status_flags: HALF_ETU_CYCLES below 2");
  end

  // read and write decode shared by several processes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic txe_q, txe_d, rxf_q, rxf_d, ore_q, ore_d;
  logic ers_q, ers_d, per_q, per_d, transmit_end_q, transmit_end_d;
  logic mpb_q, mpb_d, tx_multiproc_bit_q, tx_multiproc_bit_d;
  // armed bits remember a read of one, needed before a clear
  logic [7:0] armed_q;
  logic [7:0] armed_d;
  logic [EV_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic [7:0] rdata_q, rdata_d;
  tx_state_e tx_q, tx_d;
  logic [3:0] half_q, half_d;
  logic [3:0] target;
  logic tick;
  logic card;
  logic st_wr, st_rd;
  logic txe_sw_clr, rxf_sw_clr, ore_sw_clr, ers_sw_clr, per_sw_clr;
  logic [7:0] status_view;

  assign card = ctrl_q[C_CARD];
  assign transmit_enable = ctrl_q[C_TE];
  assign receive_enable = ctrl_q[C_RE];
  assign st_wr = wr && hit(addr, OFF_STATUS);
  assign st_rd = rd && hit(addr, OFF_STATUS);

  // clear only on zero written after a one was read; one written is ignored
  assign txe_sw_clr = st_wr && !wdata[B_TXE] && armed_q[B_TXE];
  assign rxf_sw_clr = st_wr && !wdata[B_RXF] && armed_q[B_RXF];
  assign ore_sw_clr = st_wr && !wdata[B_ORE] && armed_q[B_ORE];
  assign ers_sw_clr = st_wr && !wdata[B_ERS] && armed_q[B_ERS];
  assign per_sw_clr = st_wr && !wdata[B_PER] && armed_q[B_PER];

  // etu grid restarts at each byte start
  half_etu_tick #(
    .CNT_W(16)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .restart(tx_byte_start),
    .period(HALF_ETU_CYCLES),
    .tick(tick)
  );

  // delay choice from the two format bits
  always_comb begin
    if (ctrl_q[C_GSM]) begin
      target = HALF_ETU_1P0;
    end else if (ctrl_q[C_BLK]) begin
      target = HALF_ETU_1P5;
    end else begin
      target = HALF_ETU_2P5;
    end
  end

  // control register
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && hit(addr, OFF_CONTROL)) begin
      ctrl_d = {3'h0, wdata[4:0]};
    end
  end

  // transfer-end timer, counted in half etu steps
  always_comb begin
    tx_d = tx_q;
    half_d = half_q;
    if (tx_byte_start && card) begin
      tx_d = TX_TIMING;
      half_d = 4'h0;
    end else begin
      case (tx_q)
        TX_IDLE: begin
          tx_d = TX_IDLE;
        end
        TX_TIMING: begin
          if (tick) begin
            half_d = half_q + 4'h1;
            if (half_q + 4'h1 >= target) begin
              tx_d = TX_DONE;
            end
          end
        end
        TX_DONE: begin
          tx_d = TX_IDLE;
        end
        default: begin
          tx_d = TX_IDLE;
        end
      endcase
    end
  end

  // transmit side flags; hardware sets win over software clears
  always_comb begin
    txe_d = txe_q;
    transmit_end_d = transmit_end_q;
    if (txe_sw_clr || ctl_tx_write) begin
      txe_d = 1'b0;
      transmit_end_d = 1'b0;
    end
    if (!ctrl_q[C_TE] || tx_load) begin
      txe_d = 1'b1;
    end
    if (card) begin
      if (tx_q == TX_DONE && !ers_q && txe_q) begin
        transmit_end_d = 1'b1;
      end
      if (!ctrl_q[C_TE] && !ers_q) begin
        transmit_end_d = 1'b1;
      end
    end
  end

  // receive side flags; in card mode a byte landing on a full register raises overrun and, if its parity is bad, parity error
  always_comb begin
    rxf_d = rxf_q;
    ore_d = ore_q;
    per_d = per_q;
    mpb_d = mpb_q;
    // receive disable does not touch the full flag
    if (rxf_sw_clr || ctl_rx_read) begin
      rxf_d = 1'b0;
    end
    if (ore_sw_clr) begin
      ore_d = 1'b0;
    end
    if (per_sw_clr) begin
      per_d = 1'b0;
    end
    if (card) begin
      if (rx_done && rxf_q) begin
        ore_d = 1'b1;
      end else if (rx_done && !rx_parity_bad) begin
        rxf_d = 1'b1;
      end
      if (rx_done && rx_parity_bad) begin
        per_d = 1'b1;
      end
      mpb_d = 1'b0;
    end else if (rx_done) begin
      mpb_d = rx_mpb;
      rxf_d = 1'b1;
      ore_d = rxf_q ? 1'b1 : ore_d;
    end
  end

  // error signal flag and the software-owned transfer bit
  always_comb begin
    ers_d = ers_q;
    tx_multiproc_bit_d = tx_multiproc_bit_q;
    if (ers_sw_clr) begin
      ers_d = 1'b0;
    end
    if (card && err_sig_low) begin
      ers_d = 1'b1;
    end
    if (st_wr) begin
      tx_multiproc_bit_d = wdata[B_TX_MULTIPROC_BIT];
    end
  end

  assign status_view = {txe_q, rxf_q, ore_q, ers_q, per_q, transmit_end_q, mpb_q, tx_multiproc_bit_q};

  // arming: a read of one arms, a status write disarms unless a status read falls in the same cycle
  always_comb begin
    armed_d = armed_q;
    if (st_wr) begin
      armed_d = 8'h00;
    end
    if (st_rd) begin
      armed_d = status_view;
    end
  end

  // sticky interrupt status, set wins over clear
  always_comb begin
    logic [EV_W-1:0] ev;
    ev = '0;
    ev[EV_TXE] = txe_d && !txe_q;
    ev[EV_RXF] = rxf_d && !rxf_q;
    ev[EV_ORE] = ore_d && !ore_q;
    ev[EV_ERS] = ers_d && !ers_q;
    ev[EV_TRANSMIT_END] = transmit_end_d && !transmit_end_q;
    ien_d = ien_q;
    ist_d = ist_q;
    if (wr && hit(addr, OFF_IRQ_EN)) begin
      ien_d = wdata[EV_W-1:0];
    end
    if (wr && hit(addr, OFF_IRQ_CLR)) begin
      ist_d = ist_q & ~wdata[EV_W-1:0];
    end
    ist_d = ist_d | ev;
  end

  // read data; unmapped reads return zero; transmit_end read only
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      case (addr)
        OFF_STATUS: rdata_d = status_view;
        OFF_CONTROL: rdata_d = ctrl_q;
        OFF_IRQ_STAT: rdata_d = {3'h0, ist_q};
        OFF_IRQ_EN: rdata_d = {3'h0, ien_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // control register; format bits only matter in card mode
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CONTROL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // transfer-end timer state
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_q <= TX_IDLE;
      half_q <= 4'h0;
    end else begin
      tx_q <= tx_d;
      half_q <= half_d;
    end
  end

  // transmit side flags
  always_ff @(posedge clk) begin
    if (reset) begin
      txe_q <= STATUS_RESET[B_TXE];
      transmit_end_q <= STATUS_RESET[B_TRANSMIT_END];
    end else begin
      txe_q <= txe_d;
      transmit_end_q <= transmit_end_d;
    end
  end

  // receive side flags
  always_ff @(posedge clk) begin
    if (reset) begin
      rxf_q <= STATUS_RESET[B_RXF];
      ore_q <= STATUS_RESET[B_ORE];
      per_q <= STATUS_RESET[B_PER];
      mpb_q <= STATUS_RESET[B_MPB];
    end else begin
      rxf_q <= rxf_d;
      ore_q <= ore_d;
      per_q <= per_d;
      mpb_q <= mpb_d;
    end
  end

  // error signal flag and transfer bit
  always_ff @(posedge clk) begin
    if (reset) begin
      ers_q <= STATUS_RESET[B_ERS];
      tx_multiproc_bit_q <= STATUS_RESET[B_TX_MULTIPROC_BIT];
    end else begin
      ers_q <= ers_d;
      tx_multiproc_bit_q <= tx_multiproc_bit_d;
    end
  end

  // arming is dropped at reset so a stale read cannot clear
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 8'h00;
    end else begin
      armed_q <= armed_d;
    end
  end

  // interrupt status and enable
  always_ff @(posedge clk) begin
    if (reset) begin
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end

  // registered read data, zero outside the answer cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign tx_holding_empty = txe_q;
  assign rx_holding_full = rxf_q;
  assign irq = |(ist_q & ien_q);
endmodule

// [verification/card_flags_monitor.sv]
// port level checker for the card status flag block
`timescale 1ns/100ps
module card_flags_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [card_flags_pkg::ADDR_W-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_load,
  input wire logic rx_done,
  input wire logic rx_parity_bad,
  input wire logic ctl_tx_write,
  input wire logic ctl_rx_read,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic tx_holding_empty,
  input wire logic rx_holding_full
);
  import card_flags_pkg::*;
  logic st_wr;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // only a status write may clear a flag by software
  assign st_wr = wr && addr == OFF_STATUS;
  txe_load_a: assert property (tx_load |=> tx_holding_empty)
    else $error("tx empty not set by load");
  txe_off_a: assert property (!transmit_enable |=> tx_holding_empty)
    else $error("tx empty low while disabled");
  txe_ctl_clr_a: assert property (ctl_tx_write && transmit_enable && !tx_load |=> !tx_holding_empty)
    else $error("tx empty kept after controller write");
  txe_keep_a: assert property (tx_holding_empty && !ctl_tx_write && !st_wr |=> tx_holding_empty)
    else $error("tx empty lost");
  rxf_set_a: assert property (rx_done && !rx_parity_bad && receive_enable |=> rx_holding_full)
    else $error("rx full not set");
  rxf_ctl_clr_a: assert property (ctl_rx_read && !rx_done |=> !rx_holding_full)
    else $error("rx full kept after controller read");
  rxf_keep_a: assert property (rx_holding_full && !ctl_rx_read && !st_wr |=> rx_holding_full)
    else $error("rx full lost");
  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  cover property (rx_done && rx_holding_full);
  cover property (ctl_tx_write ##1 tx_load);
  cover property (ctl_rx_read && rx_holding_full);
endmodule
bind card_status_flags card_flags_monitor card_flags_monitor_i (.clk, .reset, .addr, .wr, .rd, .rdata,
  .tx_load, .rx_done, .rx_parity_bad, .ctl_tx_write, .ctl_rx_read, .transmit_enable, .receive_enable,
  .tx_holding_empty, .rx_holding_full);

// [verification/smart_card_model.sv]
// behavioural smart card on the far side of the channel
`timescale 1ns/100ps
module smart_card_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go_rx,
  input wire logic bad_par,
  input wire logic go_nack,
  input wire logic [3:0] lag,
  output logic rx_done,
  output logic rx_parity_bad,
  output logic rx_mpb,
  output logic err_sig_low
);
  logic [3:0] cnt_q, cnt_d;
  logic par_q, par_d, nack_q, nack_d;
  // byte lands lag cycles after the request, so answers can be prompt or slow
  always_comb begin
    cnt_d = cnt_q;
    par_d = par_q;
    nack_d = go_nack;
    if (go_rx) begin
      cnt_d = lag;
      par_d = bad_par;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 4'h0;
      par_q <= 1'h0;
      nack_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      par_q <= par_d;
      nack_q <= nack_d;
    end
  end
  assign rx_done = cnt_q == 4'h1;
  // parity only valid with done, so it wanders otherwise
  assign rx_parity_bad = rx_done ? par_q : cnt_q[0];
  // stale bit held high so the card mode mask shows
  assign rx_mpb = 1'h1;
  assign err_sig_low = nack_q;
endmodule

// [verification/test_card_status_flags.sv]
// self-checking bench for the card status flag block
`timescale 1ns/100ps
module test_card_status_flags;
  import card_flags_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0] n;
  } row_s;
  row_s rows [4] = '{'{8'h07, 4'h5}, '{8'h17, 4'h3}, '{8'h0f, 4'h2}, '{8'h1f, 4'h2}};
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] addr = 4'h0, lag = 4'h1;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic wr = 1'h0, rd = 1'h0, tx_load = 1'h0, tx_byte_start = 1'h0, ctl_tx_write = 1'h0;
  logic ctl_rx_read = 1'h0, go_rx = 1'h0, bad_par = 1'h0, go_nack = 1'h0;
  logic rx_done, rx_parity_bad, rx_mpb, err_sig_low, irq;
  logic transmit_enable, receive_enable, tx_holding_empty, rx_holding_full;
  int n_errors = 0, checks_done = 0, cyc = 0, t0;
  card_status_flags #(.HALF_ETU_CYCLES(16'h0008)) card_status_flags_i (.clk, .reset, .addr, .wdata, .wr,
    .rd, .rdata, .tx_load, .tx_byte_start, .rx_done, .rx_parity_bad, .rx_mpb, .err_sig_low, .ctl_tx_write,
    .ctl_rx_read, .transmit_enable, .receive_enable, .tx_holding_empty, .rx_holding_full, .irq);
  smart_card_model smart_card_model_i (.clk, .reset, .go_rx, .bad_par, .go_nack, .lag, .rx_done,
    .rx_parity_bad, .rx_mpb, .err_sig_low);
  // 50 MHz clock and a cycle count for delay checks
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // read data is sampled in its one valid cycle
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic card_byte(input logic bad, input logic [3:0] l);
    @(posedge clk);
    go_rx <= 1'h1;
    bad_par <= bad;
    lag <= l;
    @(posedge clk);
    go_rx <= 1'h0;
    repeat (12) @(posedge clk);
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    rd_reg(OFF_STATUS, d);
    chk(d, 8'h84);
    // one row per setting of the two format bits: clear, load, start, poll for transmit end
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFF_CONTROL, rows[i].ctl);
      @(posedge clk) ctl_tx_write <= 1'h1;
      @(posedge clk) ctl_tx_write <= 1'h0;
      rd_reg(OFF_STATUS, d);
      chk(d & 8'h84, 8'h00);
      @(posedge clk) tx_load <= 1'h1;
      @(posedge clk) tx_load <= 1'h0;
      tx_byte_start <= 1'h1;
      t0 = cyc;
      @(posedge clk) tx_byte_start <= 1'h0;
      for (int k = 0; k < 40 && d[B_TRANSMIT_END] !== 1'h1; k++) rd_reg(OFF_STATUS, d);
      chk(8'(cyc - t0 >= rows[i].n * 8 && cyc - t0 <= rows[i].n * 8 + 7), 8'h01);
    end
    // ones and unarmed zeros leave flags alone
    wr_reg(OFF_STATUS, 8'hfe);
    wr_reg(OFF_STATUS, 8'h00);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h84, 8'h84);
    wr_reg(OFF_STATUS, 8'h00);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h84, 8'h00);
    chk({6'h00, tx_holding_empty, rx_holding_full}, 8'h00);
    card_byte(1'h0, 4'h1);
    chk(8'(rx_holding_full), 8'h01);
    card_byte(1'h0, 4'h9);
    card_byte(1'h1, 4'h1);
    wr_reg(OFF_CONTROL, 8'h1d);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h6a, 8'h68);
    chk({6'h00, receive_enable, transmit_enable}, 8'h01);
    @(posedge clk) ctl_rx_read <= 1'h1;
    @(posedge clk) ctl_rx_read <= 1'h0;
    #1 chk(8'(rx_holding_full), 8'h00);
    wr_reg(OFF_STATUS, 8'h00);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h28, 8'h00);
    // error signal raises, masks and clears the interrupt
    wr_reg(OFF_IRQ_CLR, 8'h1f);
    wr_reg(OFF_IRQ_EN, 8'h08);
    @(posedge clk) go_nack <= 1'h1;
    @(posedge clk) go_nack <= 1'h0;
    repeat (3) @(posedge clk);
    #1 chk(8'(irq), 8'h01);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h10, 8'h10);
    wr_reg(OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(8'(irq), 8'h00);
    wr_reg(OFF_IRQ_CLR, 8'h08);
    rd_reg(OFF_IRQ_STAT, d);
    chk(d & 8'h08, 8'h00);
    rd_reg(4'hf, d);
    chk(d, 8'h00);
    wr_reg(OFF_STATUS, 8'h00);
    wr_reg(OFF_CONTROL, 8'h04);
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h94, 8'h84);
    // outside card mode parity and error signal leave no mark, mpb follows the line
    wr_reg(OFF_CONTROL, 8'h03);
    card_byte(1'h1, 4'h1);
    @(posedge clk) go_nack <= 1'h1;
    @(posedge clk) go_nack <= 1'h0;
    rd_reg(OFF_STATUS, d);
    chk(d & 8'h5a, 8'h42);
    // mid-run reset brings back the reset view
    @(posedge clk) reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rd_reg(OFF_STATUS, d);
    chk(d, STATUS_RESET);
    rd_reg(OFF_CONTROL, d);
    chk(d, CONTROL_RESET);
    give_verdict();
  end
endmodule
